// >>> src/dcam_pkg.sv
// Behaviour
// - Two alarm channels, each judging its own condition independently.
// - Rate period equals the sample count times the current sample period.
// - Threshold bit 15 high trips above threshold, low trips below it.
// - Threshold bits 13:0 share the numeric format of the selected source.
// - Sample count bits 7:0 set the rate depth; zero and one both mean one.
// - Control bit 15 picks rate-of-change for alarm two, else static level.
// - Control bits 14:12 pick alarm two source; 000 and unused codes disable.
// - Control bit 11 picks rate-of-change for alarm one, else static level.
// - Control bits 10:8 pick alarm one source with the same encoding.
// - Control bit 4 makes both alarms use filtered data, else raw data.
// - Control bit 2 lets the alarm drive a pin; clear leaves pins undriven.
// - Control bit 1 makes the alarm output active high, else active low.
// - Control bit 0 routes the alarm to pin two, else to pin one.
// - Thresholds, counts and control reset to zero: alarms off, pin undriven.
// - Status bit 8 shows alarm one active, bit 9 alarm two active.
// - Reading status clears its flags; a lasting condition sets them next sample.
// - Period setting zero gives the fastest rate, one sample every BASE_CYCLES clocks.
package dcam_pkg;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 7;
  localparam logic [6:0] OFF_THR1 = 7'h20;
  localparam logic [6:0] OFF_THR2 = 7'h22;
  localparam logic [6:0] OFF_CNT1 = 7'h24;
  localparam logic [6:0] OFF_CNT2 = 7'h26;
  localparam logic [6:0] OFF_CTRL = 7'h28;
  localparam logic [6:0] OFF_STATUS = 7'h3c;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] THR_MASK = 16'hbfff;
  localparam logic [15:0] CNT_MASK = 16'h00ff;
  localparam logic [15:0] CTRL_MASK = 16'hff17;

  // ==========================================================
  // Field positions
  localparam int THR_POL = 15;
  localparam int DATA_W = 14;
  localparam int CNT_W = 8;
  localparam int CTRL_SRC_LO = 8;
  localparam int CTRL_RATE = 11;
  localparam int CTRL_CH_STRIDE = 4;
  localparam int CTRL_FILT = 4;
  localparam int CTRL_OUT_EN = 2;
  localparam int CTRL_POL = 1;
  localparam int CTRL_LINE = 0;
  localparam int STAT_ALM = 8;
  localparam int NUM_CH = 2;
  localparam int HIST_DEPTH = 256;

  // ==========================================================
  // Timing
  localparam int CLOCK_HZ = 50_000_000;
  localparam int BASE_SPS = 2429;
  localparam int BASE_CYCLES = CLOCK_HZ / BASE_SPS;
  localparam int DIV_W = 24;

  typedef enum logic [2:0] {
    DCAM_SRC_OFF = 3'b000,
    DCAM_SRC_SUPPLY = 3'b001,
    DCAM_SRC_ROTATION = 3'b010,
    DCAM_SRC_AUX = 3'b101,
    DCAM_SRC_TEMP = 3'b110
  } dcam_src_sel_t;

  typedef struct packed {
    logic [13:0] supply;
    logic [13:0] rotation;
    logic [13:0] aux;
    logic [13:0] temperature;
  } dcam_src_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dcam_reg_req_t;

endpackage

// >>> src/dcam_alarm_chan.sv
`timescale 1ns/10ps
module dcam_alarm_chan (
  input logic clock,
  input logic rst_n,
  input logic sample_en,
  input logic enable,
  input logic rate_mode,
  input logic [13:0] sample_data,
  input logic [7:0] sample_count,
  input logic [15:0] threshold,
  output logic alarm,
  output logic done
);

  typedef struct packed {
    logic [7:0] wptr;
    logic [8:0] fill;
    logic alarm;
    logic done;
  } dcam_chan_state_t;

  dcam_chan_state_t st;
  dcam_chan_state_t next_st;
  logic [13:0] hist [dcam_pkg::HIST_DEPTH];
  logic [7:0] depth;
  logic [13:0] old_sample;
  logic signed [14:0] value;
  logic signed [14:0] limit;
  logic trip;

  // ==========================================================
  // Comparison datapath
  // Count floor one
  assign depth = (sample_count <= 8'h01) ? 8'h01 : sample_count;
  assign old_sample = hist[8'(st.wptr - depth)];
  assign value = rate_mode ? ($signed({sample_data[13], sample_data})
                             - $signed({old_sample[13], old_sample}))
                           : $signed({sample_data[13], sample_data});
  assign limit = $signed({threshold[13], threshold[13:0]});
  assign trip = threshold[dcam_pkg::THR_POL] ? (value > limit) : (value < limit);

  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (sample_en)
    begin
      next_st.done = 1'b1;
      if (enable)
      begin
        next_st.wptr = 8'(st.wptr + 8'h01);
        if (st.fill != 9'(dcam_pkg::HIST_DEPTH))
        begin
          next_st.fill = 9'(st.fill + 9'h001);
        end
        next_st.alarm = trip & (!rate_mode | (st.fill >= {1'b0, depth}));
      end
      else
      begin
        next_st.fill = 9'h000;
        next_st.alarm = 1'b0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // History store needs no reset; fill gates its use
  always_ff @(posedge clock)
  begin
    if (sample_en && enable)
    begin
      hist[st.wptr] <= sample_data;
    end
  end

  assign alarm = st.alarm;
  assign done = st.done;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_static_above: assert property (
    sample_en && enable && !rate_mode && threshold[dcam_pkg::THR_POL]
    && ($signed(sample_data) > $signed(threshold[13:0])) |=> alarm && done)
    else $error("static alarm missed above threshold");
  chk_static_below: assert property (
    sample_en && enable && !rate_mode && !threshold[dcam_pkg::THR_POL]
    && ($signed(sample_data) >= $signed(threshold[13:0])) |=> !alarm)
    else $error("static alarm raised while not below threshold");
  chk_rate_history: assert property (
    sample_en && enable && rate_mode && (st.fill == 9'h000) |=> !alarm)
    else $error("rate alarm raised without history");
  chk_disabled_idle: assert property (
    sample_en && !enable |=> !alarm ##1 !done)
    else $error("disabled channel raised alarm");

endmodule // dcam_alarm_chan

// >>> src/dcam_alarm_top.sv
`timescale 1ns/10ps
module dcam_alarm_top #(
  parameter int BASE_CYCLES = dcam_pkg::BASE_CYCLES
) (
  input logic clock,
  input logic rst_n,
  input dcam_pkg::dcam_reg_req_t reg_req,
  output logic [15:0] reg_rd_data,
  input logic [7:0] sample_period_setting,
  input dcam_pkg::dcam_src_t src_raw,
  input dcam_pkg::dcam_src_t src_filt,
  output logic [1:0] alarm_active,
  output logic general_pin_one_out,
  output logic general_pin_one_oe,
  output logic general_pin_two_out,
  output logic general_pin_two_oe
);

  typedef struct packed {
    logic [1:0][15:0] thr;
    logic [1:0][15:0] cnt;
    logic [15:0] ctrl;
    logic [1:0] flag;
    logic [23:0] div;
    logic [7:0] per;
    logic sample_en;
    logic [15:0] rd_data;
  } dcam_top_state_t;

  dcam_top_state_t st;
  dcam_top_state_t next_st;
  dcam_pkg::dcam_src_t src_sel;
  logic [1:0] chan_alarm;
  logic [1:0] chan_done;
  logic [1:0] chan_en;
  logic [1:0] flag_set;
  logic read_status;
  logic any_alarm;
  logic pin_level;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] put_byte(
    input logic [15:0] word,
    input logic high,
    input logic [7:0] data,
    input logic [15:0] mask
  );
    logic [15:0] merged;
    merged = high ? {data, word[7:0]} : {word[15:8], data};
    return merged & mask;
  endfunction

  function automatic logic [13:0] pick_source(
    input dcam_pkg::dcam_src_t src,
    input logic [2:0] code
  );
    logic [13:0] data;
    case (code)
      dcam_pkg::DCAM_SRC_SUPPLY: data = src.supply;
      dcam_pkg::DCAM_SRC_ROTATION: data = src.rotation;
      dcam_pkg::DCAM_SRC_AUX: data = src.aux;
      dcam_pkg::DCAM_SRC_TEMP: data = src.temperature;
      default: data = 14'h0000;
    endcase
    return data;
  endfunction

  function automatic logic source_valid(input logic [2:0] code);
    logic ok;
    case (code)
      dcam_pkg::DCAM_SRC_SUPPLY: ok = 1'b1;
      dcam_pkg::DCAM_SRC_ROTATION: ok = 1'b1;
      dcam_pkg::DCAM_SRC_AUX: ok = 1'b1;
      dcam_pkg::DCAM_SRC_TEMP: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ==========================================================
  // Filter choice shared by both channels
  // Filtered or raw
  assign src_sel = st.ctrl[dcam_pkg::CTRL_FILT] ? src_filt : src_raw;

  // ==========================================================
  // Alarm channels
  // Independent channel pair
  for (genvar i = 0; i < dcam_pkg::NUM_CH; i++)
  begin : g_chan
    localparam int SRC_LO = dcam_pkg::CTRL_SRC_LO + i * dcam_pkg::CTRL_CH_STRIDE;
    localparam int RATE_BIT = dcam_pkg::CTRL_RATE + i * dcam_pkg::CTRL_CH_STRIDE;
    logic [2:0] code;
    logic [13:0] data;

    assign code = st.ctrl[SRC_LO +: 3];
    assign data = pick_source(src_sel, code);
    assign chan_en[i] = source_valid(code);

    dcam_alarm_chan u_chan (
      .clock(clock),
      .rst_n(rst_n),
      .sample_en(st.sample_en),
      .enable(chan_en[i]),
      .rate_mode(st.ctrl[RATE_BIT]),
      .sample_data(data),
      .sample_count(st.cnt[i][dcam_pkg::CNT_W-1:0]),
      .threshold(st.thr[i]),
      .alarm(chan_alarm[i]),
      .done(chan_done[i])
    );
  end

  // ==========================================================
  // Status flags and register access
  assign flag_set = chan_done & chan_alarm;
  assign read_status = reg_req.rd_en && (reg_req.addr[6:1] == dcam_pkg::OFF_STATUS[6:1]);

  always_comb
  begin
    next_st = st;
    next_st.sample_en = 1'b0;

    if (st.div >= 24'(BASE_CYCLES - 1))
    begin
      next_st.div = 24'h00_0000;
      if (st.per >= sample_period_setting)
      begin
        next_st.per = 8'h00;
        next_st.sample_en = 1'b1;
      end
      else
      begin
        next_st.per = 8'(st.per + 8'h01);
      end
    end
    else
    begin
      next_st.div = 24'(st.div + 24'h00_0001);
    end

    if (reg_req.wr_en)
    begin
      if (reg_req.addr[6:1] == dcam_pkg::OFF_THR1[6:1])
      begin
        next_st.thr[0] = put_byte(st.thr[0], reg_req.addr[0], reg_req.wdata,
                                  dcam_pkg::THR_MASK);
      end
      else if (reg_req.addr[6:1] == dcam_pkg::OFF_THR2[6:1])
      begin
        next_st.thr[1] = put_byte(st.thr[1], reg_req.addr[0], reg_req.wdata,
                                  dcam_pkg::THR_MASK);
      end
      else if (reg_req.addr[6:1] == dcam_pkg::OFF_CNT1[6:1])
      begin
        next_st.cnt[0] = put_byte(st.cnt[0], reg_req.addr[0], reg_req.wdata,
                                  dcam_pkg::CNT_MASK);
      end
      else if (reg_req.addr[6:1] == dcam_pkg::OFF_CNT2[6:1])
      begin
        next_st.cnt[1] = put_byte(st.cnt[1], reg_req.addr[0], reg_req.wdata,
                                  dcam_pkg::CNT_MASK);
      end
      else if (reg_req.addr[6:1] == dcam_pkg::OFF_CTRL[6:1])
      begin
        next_st.ctrl = put_byte(st.ctrl, reg_req.addr[0], reg_req.wdata,
                                dcam_pkg::CTRL_MASK);
      end
    end

    if (reg_req.rd_en)
    begin
      if (reg_req.addr[6:1] == dcam_pkg::OFF_THR1[6:1])
      begin
        next_st.rd_data = st.thr[0];
      end
      else if (reg_req.addr[6:1] == dcam_pkg::OFF_THR2[6:1])
      begin
        next_st.rd_data = st.thr[1];
      end
      else if (reg_req.addr[6:1] == dcam_pkg::OFF_CNT1[6:1])
      begin
        next_st.rd_data = st.cnt[0];
      end
      else if (reg_req.addr[6:1] == dcam_pkg::OFF_CNT2[6:1])
      begin
        next_st.rd_data = st.cnt[1];
      end
      else if (reg_req.addr[6:1] == dcam_pkg::OFF_CTRL[6:1])
      begin
        next_st.rd_data = st.ctrl;
      end
      else if (read_status)
      begin
        next_st.rd_data = 16'h0000;
        next_st.rd_data[dcam_pkg::STAT_ALM +: 2] = st.flag;
      end
      else
      begin
        next_st.rd_data = 16'h0000;
      end
    end

    next_st.flag = (read_status ? 2'b00 : st.flag) | flag_set;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Alarm indicator pin
  assign any_alarm = |chan_alarm;
  assign pin_level = st.ctrl[dcam_pkg::CTRL_POL] ? any_alarm : !any_alarm;
  assign general_pin_one_oe = st.ctrl[dcam_pkg::CTRL_OUT_EN] && !st.ctrl[dcam_pkg::CTRL_LINE];
  assign general_pin_two_oe = st.ctrl[dcam_pkg::CTRL_OUT_EN] && st.ctrl[dcam_pkg::CTRL_LINE];
  assign general_pin_one_out = general_pin_one_oe && pin_level;
  assign general_pin_two_out = general_pin_two_oe && pin_level;
  assign alarm_active = chan_alarm;
  assign reg_rd_data = st.rd_data;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_reset_zero: assert property (@(posedge clock) disable iff (1'b0)
    !rst_n |=> (st.ctrl == 16'h0000) && (st.thr == '0) && (st.cnt == '0)
    && !general_pin_one_oe && !general_pin_two_oe)
    else $error("settings not zero after reset");
  chk_pin_off: assert property (
    !st.ctrl[dcam_pkg::CTRL_OUT_EN] |-> !general_pin_one_oe && !general_pin_two_oe)
    else $error("pin driven while output disabled");
  chk_pin_route: assert property (
    st.ctrl[dcam_pkg::CTRL_OUT_EN] |->
    (general_pin_two_oe == st.ctrl[dcam_pkg::CTRL_LINE])
    && (general_pin_one_oe != st.ctrl[dcam_pkg::CTRL_LINE]))
    else $error("alarm routed to wrong pin");
  chk_pin_polarity: assert property (
    general_pin_one_oe |->
    general_pin_one_out == (st.ctrl[dcam_pkg::CTRL_POL] ~^ any_alarm))
    else $error("alarm pin polarity wrong");
  chk_flag_set: assert property (
    chan_done[1] && chan_alarm[1] |=> st.flag[1] ##1 $past(read_status) || st.flag[1])
    else $error("alarm two flag not set");
  chk_read_clear: assert property (
    read_status && (flag_set == 2'b00) |=> (st.flag == 2'b00)
    && (reg_rd_data[dcam_pkg::STAT_ALM +: 2] == $past(st.flag)))
    else $error("status read did not clear or report flags");
  chk_sample_gap: assert property (
    st.sample_en |=> !st.sample_en)
    else $error("sample enable longer than one cycle");

  // ==========================================================
  // Checks on register contents
  chk_thr_mask: assert property (
    ((st.thr[0] | st.thr[1]) & ~dcam_pkg::THR_MASK) == 16'h0000)
    else $error("threshold reserved bit stored");
  chk_count_mask: assert property (
    ((st.cnt[0] | st.cnt[1]) & ~dcam_pkg::CNT_MASK) == 16'h0000)
    else $error("sample count reserved bits stored");
  chk_ctrl_write: assert property (
    reg_req.wr_en && (reg_req.addr == (dcam_pkg::OFF_CTRL | 7'h01))
    |=> st.ctrl[dcam_pkg::CTRL_SRC_LO +: 8] == $past(reg_req.wdata))
    else $error("control high byte write lost");
  chk_status_rsvd: assert property (
    read_status |=> (reg_rd_data[dcam_pkg::STAT_ALM-1:0] == 8'h00)
    && ((reg_rd_data >> (dcam_pkg::STAT_ALM + dcam_pkg::NUM_CH)) == 16'h0000))
    else $error("status unused bits not zero");
  chk_read_thr: assert property (
    reg_req.rd_en && (reg_req.addr[6:1] == dcam_pkg::OFF_THR1[6:1])
    |=> reg_rd_data == $past(st.thr[0]))
    else $error("threshold read back wrong");
  chk_rd_stand: assert property (
    !reg_req.rd_en |=> $stable(reg_rd_data))
    else $error("read word changed without a read");
  chk_reset_outputs: assert property (@(posedge clock) disable iff (1'b0)
    !rst_n |=> (reg_rd_data == 16'h0000) && (alarm_active == 2'b00))
    else $error("outputs not zero after reset");

  // ==========================================================
  // Checks on flags and sampling
  chk_flag_one_set: assert property (
    chan_done[0] && chan_alarm[0] |=> st.flag[0])
    else $error("alarm one flag not set");
  chk_flag_hold: assert property (
    !read_status |=> (st.flag & $past(st.flag)) == $past(st.flag))
    else $error("alarm flag dropped without a status read");
  chk_flag_cause: assert property (
    (flag_set == 2'b00) && (st.flag == 2'b00) |=> st.flag == 2'b00)
    else $error("alarm flag set without an alarm result");
  chk_source_off: assert property (
    (chan_done & chan_alarm & ~$past(chan_en)) == 2'b00)
    else $error("alarm from a disabled source");
  chk_done_timing: assert property (
    st.sample_en |=> chan_done == 2'b11)
    else $error("channels not judged after sample enable");
  chk_sample_start: assert property (
    st.sample_en |-> (st.div == 24'h00_0000) && (st.per == 8'h00))
    else $error("sample enable off the time base");
  chk_sample_period: assert property (
    (st.div == 24'(BASE_CYCLES - 1)) && (st.per >= sample_period_setting)
    |=> st.sample_en)
    else $error("sample enable missed at period end");

  // ==========================================================
  // Checks on the indicator pins
  chk_pin_two_pol: assert property (
    general_pin_two_oe |->
    general_pin_two_out == (st.ctrl[dcam_pkg::CTRL_POL] ~^ any_alarm))
    else $error("alarm pin two polarity wrong");
  chk_pin_quiet: assert property (
    (general_pin_one_oe || !general_pin_one_out)
    && (general_pin_two_oe || !general_pin_two_out))
    else $error("undriven pin shows a level");
  chk_line_one: assert property (
    st.ctrl[dcam_pkg::CTRL_OUT_EN] && !st.ctrl[dcam_pkg::CTRL_LINE]
    |-> general_pin_one_oe && !general_pin_two_oe)
    else $error("alarm not routed to pin one");

  cov_alarm_one: cover property (chan_done[0] && chan_alarm[0]);
  cov_alarm_two_rate: cover property (chan_done[1] && chan_alarm[1]
    && st.ctrl[dcam_pkg::CTRL_RATE + dcam_pkg::CTRL_CH_STRIDE]);
  cov_read_clear: cover property (read_status && (st.flag != 2'b00));
  cov_pin_two: cover property (general_pin_two_oe && any_alarm);
  cov_pin_one_low: cover property (general_pin_one_oe && !st.ctrl[dcam_pkg::CTRL_POL] && any_alarm);

endmodule // dcam_alarm_top

// >>> sim/dcam_host_model.sv
`timescale 1ns/10ps
// ==========================================================
// Host side of the register port: byte writes, word reads
module dcam_host_model (
  input wire logic clock,
  output dcam_pkg::dcam_reg_req_t reg_req,
  input wire logic [15:0] reg_rd_data
);
  initial reg_req = '0;

  // Low byte first, then high byte on the next cycle
  task automatic wr(input logic [6:0] addr, input logic [15:0] word);
    @(negedge clock);
    reg_req <= {1'b1, 1'b0, addr, word[7:0]};
    @(negedge clock);
    reg_req <= {1'b1, 1'b0, addr | 7'h01, word[15:8]};
    @(negedge clock);
    reg_req <= '0;
  endtask

  // Read word is taken once the answer has settled
  task automatic rd(input logic [6:0] addr, output logic [15:0] word);
    @(negedge clock);
    reg_req <= {1'b0, 1'b1, addr, 8'h00};
    @(negedge clock);
    reg_req <= '0;
    @(negedge clock);
    word = reg_rd_data;
  endtask
endmodule // dcam_host_model

// >>> sim/dual_condition_alarm_monitor_test.sv
`timescale 1ns/10ps
module dual_condition_alarm_monitor_test;
  localparam int BC = 8;
  localparam logic [6:0] OFFS [5] = '{7'h20, 7'h22, 7'h24, 7'h26, 7'h28};
  localparam logic [15:0] MASKS [5] = '{16'hbfff, 16'hbfff, 16'h00ff, 16'h00ff, 16'hff17};
  localparam int S_TAB [4] = '{0, 0, 0, 1};
  localparam int C_TAB [4] = '{0, 1, 4, 3};
  logic clock;
  logic rst_n;
  dcam_pkg::dcam_reg_req_t reg_req;
  logic [15:0] reg_rd_data;
  logic [7:0] sample_period_setting;
  dcam_pkg::dcam_src_t src_raw;
  dcam_pkg::dcam_src_t src_filt;
  logic [1:0] alarm_active;
  logic p1_out, p1_oe, p2_out, p2_oe;
  int err_count;
  int num_checks;
  integer seed;
  logic ramp_on;
  logic [15:0] v;
  logic [15:0] ctrl;
  logic [15:0] thr [2];
  logic [1:0] ea;
  int d;

  dcam_alarm_top #(.BASE_CYCLES(BC)) dcam_alarm_top_inst (
    .clock(clock),
    .rst_n(rst_n),
    .reg_req(reg_req),
    .reg_rd_data(reg_rd_data),
    .sample_period_setting(sample_period_setting),
    .src_raw(src_raw),
    .src_filt(src_filt),
    .alarm_active(alarm_active),
    .general_pin_one_out(p1_out),
    .general_pin_one_oe(p1_oe),
    .general_pin_two_out(p2_out),
    .general_pin_two_oe(p2_oe)
  );

  dcam_host_model dcam_host_model_inst (
    .clock(clock),
    .reg_req(reg_req),
    .reg_rd_data(reg_rd_data)
  );

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Steady ramp gives a known difference per sample period
  always @(negedge clock)
    if (ramp_on) src_raw.rotation <= src_raw.rotation + 14'h0001;

  // ==========================================================
  // Expectations
  function automatic logic chan_exp(logic [15:0] t, dcam_pkg::dcam_src_t s, logic [2:0] c);
    logic [13:0] x;
    case (c)
      3'h1: x = s.supply;
      3'h2: x = s.rotation;
      3'h5: x = s.aux;
      3'h6: x = s.temperature;
      default: return 1'b0;
    endcase
    return t[15] ? ($signed(x) > $signed(t[13:0])) : ($signed(x) < $signed(t[13:0]));
  endfunction

  function automatic logic [3:0] pins_exp(logic [15:0] c, logic [1:0] a);
    logic lvl;
    lvl = c[1] ? |a : ~|a;
    return {c[2] & ~c[0], c[2] & ~c[0] & lvl, c[2] & c[0], c[2] & c[0] & lvl};
  endfunction

  // ==========================================================
  // Helpers
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic w(input logic [6:0] a, input logic [15:0] x);
    dcam_host_model_inst.wr(a, x);
  endtask

  task automatic r(input logic [6:0] a, output logic [15:0] x);
    dcam_host_model_inst.rd(a, x);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask

  function automatic logic [15:0] pins_now();
    return 16'({p1_oe, p1_out, p2_oe, p2_out});
  endfunction

  // ==========================================================
  // Main sequence
  initial
  begin
    err_count = 0;
    num_checks = 0;
    seed = 27531;
    rst_n = 1'b0;
    ramp_on = 1'b0;
    sample_period_setting = 8'h00;
    src_raw = '0;
    src_filt = '0;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      r(OFFS[i], v);
      check("reset_value", v, 16'h0000);
    end
    check("reset_pins", pins_now(), 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      w(OFFS[i], 16'hffff);
      r(OFFS[i], v);
      check("reserved_bits", v, MASKS[i]);
    end
    r(7'h30, v);
    check("unmapped_read", v, 16'h0000);
    // Random configurations, every source code on both channels
    for (int i = 0; i < 40; i++)
    begin
      ctrl = 16'($random(seed)) & 16'h0017;
      ctrl[10:8] = 3'(i);
      ctrl[14:12] = 3'(i + 3);
      src_raw = 56'({$random(seed), $random(seed)});
      src_filt = 56'({$random(seed), $random(seed)});
      sample_period_setting = 8'($random(seed) & 1);
      thr[0] = 16'($random(seed)) & 16'hbfff;
      thr[1] = 16'($random(seed)) & 16'hbfff;
      if (i % 8 == 2)
        thr[0][13:0] = ctrl[4] ? src_filt.rotation : src_raw.rotation;
      w(7'h20, thr[0]);
      w(7'h22, thr[1]);
      w(7'h28, ctrl);
      ea[0] = chan_exp(thr[0], ctrl[4] ? src_filt : src_raw, ctrl[10:8]);
      ea[1] = chan_exp(thr[1], ctrl[4] ? src_filt : src_raw, ctrl[14:12]);
      settle(40);
      r(7'h3c, v);
      settle(40);
      check("alarm_level", 16'(alarm_active), 16'(ea));
      check("pins", pins_now(), 16'(pins_exp(ctrl, ea)));
      r(7'h3c, v);
      check("status", v, {6'h00, ea, 8'h00});
    end
    // Known static case, then flags outlive a disabled alarm until read
    src_filt.rotation = 14'h03e9;
    src_raw = src_filt;
    w(7'h20, 16'h83e8);
    w(7'h22, 16'h3830);
    w(7'h28, 16'h2217);
    r(7'h3c, v);
    settle(40);
    check("example_pins", 16'({alarm_active, 4'(pins_now())}), 16'h0013);
    w(7'h28, 16'h0000);
    settle(40);
    check("disabled_pins", pins_now(), 16'h0000);
    r(7'h3c, v);
    check("sticky_status", v, 16'h0100);
    r(7'h3c, v);
    check("cleared_status", v, 16'h0000);
    // Rate of change on a ramp: difference is period times count
    ramp_on = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      w(7'h28, 16'h0000);
      sample_period_setting = 8'(S_TAB[k]);
      d = BC * (S_TAB[k] + 1) * (C_TAB[k] == 0 ? 1 : C_TAB[k]);
      w(7'h20, 16'h8000 | 16'(d - 1));
      w(7'h22, 16'h8000 | 16'(d));
      w(7'h24, 16'(C_TAB[k]));
      w(7'h26, 16'(C_TAB[k]));
      w(7'h28, 16'haa00);
      settle((C_TAB[k] + 5) * BC * (S_TAB[k] + 1) + 10);
      check("rate_alarm", 16'(alarm_active), 16'h0001);
    end
    ramp_on = 1'b0;
    print_verdict();
  end

  // Cuts a hang short well beyond the expected run
  initial
  begin
    #400000;
    err_count++;
    print_verdict();
  end
endmodule // dual_condition_alarm_monitor_test
